/* core/piso_pkg.sv */
package piso_pkg;
   localparam int WORD_W = 16;
   localparam int TOP_BIT = 15;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_STAGES = 3;
   localparam logic [15:0] REG_RESET = 16'h0000;

   typedef struct packed {
      logic [15:0] word;
   } word_t;

   typedef struct packed {
      logic cs_n;
      logic mode;
      logic serial_in;
      logic clk_pin;
   } pins_t;

   localparam pins_t PINS_IDLE = '{cs_n: 1'b1, mode: 1'b0, serial_in: 1'b0,
                                   clk_pin: 1'b0};
endpackage : piso_pkg

/* core/piso_shift_register_16.sv */
`timescale 1ns/10ps
// Contract
// - Sixteen edge-triggered stages, filled by word or bit, one output.
// - Mode high and selected: falling pin clock edge loads the next buffered word; with none buffered, word kept.
// - Mode low and selected: falling edge shifts up, serial bit enters.
// - Chip select high: clock edges ignored, word kept.
// - Stages change only on the falling edge of the pin clock.
// - Serial output always shows bit fifteen.
module piso_shift_register_16
   import piso_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [15:0] parallel_word_in,
   input wire logic parallel_word_valid,
   output logic parallel_word_ready,
   input wire logic falling_edge_clock,
   input wire logic mode_load,
   input wire logic serial_in,
   input wire logic chip_select_n,
   output logic top_stage_bit,
   output logic word_consumed
);
   // ------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------
   // Keep the accepted level until stages two and three agree
   function automatic pins_t settle(pins_t newer, pins_t older, pins_t held);
      pins_t agree;
      agree = pins_t'(~(newer ^ older));
      settle = pins_t'((agree & newer) | (~agree & held));
   endfunction : settle

   pins_t pins_raw;
   pins_t s1_q;
   pins_t s2_q;
   pins_t s3_q;
   pins_t pin_q;
   pins_t pin_d;

   assign pins_raw = '{cs_n: chip_select_n, mode: mode_load,
                       serial_in: serial_in, clk_pin: falling_edge_clock};

   // First stage may go metastable; only the second reads it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= PINS_IDLE;
      end else begin
         s1_q <= pins_raw;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s2_q <= PINS_IDLE;
      end else begin
         s2_q <= s1_q;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s3_q <= PINS_IDLE;
      end else begin
         s3_q <= s2_q;
      end
   end

   // A one-cycle glitch never reaches the register logic
   assign pin_d = settle(s2_q, s3_q, pin_q);

   // Pin clock idles low, so no false edge follows reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= PINS_IDLE;
      end else begin
         pin_q <= pin_d;
      end
   end

   // ------------------------------------------------
   // Pin decode
   // ------------------------------------------------
   word_t fifo_word;
   logic fifo_valid;

   wire clk_now = pin_d.clk_pin;
   wire clk_was = pin_q.clk_pin;
   wire bit_in = pin_d.serial_in;
   wire want_load = pin_d.mode;
   wire selected = !pin_d.cs_n;
   // Rising pin clock edges do nothing
   wire fall_ev = clk_was && !clk_now;
   wire act_ev = fall_ev && selected;
   // Load waits for a buffered word; with none, the edge holds the word
   wire load_ev = act_ev && want_load && fifo_valid;
   wire shift_ev = act_ev && !want_load;

   // ------------------------------------------------
   // Word buffer
   // ------------------------------------------------
   // Far side need not time its words to the pin clock
   word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_data(parallel_word_in),
      .in_valid(parallel_word_valid),
      .in_ready(parallel_word_ready),
      .out_data(fifo_word),
      .out_valid(fifo_valid),
      .out_ready(load_ev)
   );

   // ------------------------------------------------
   // Shift register
   // ------------------------------------------------
   function automatic logic [15:0] shift_up(logic [15:0] word, logic fill);
      shift_up = {word[TOP_BIT-1:0], fill};
   endfunction : shift_up

   logic [15:0] stages_q;
   logic [15:0] stages_d;
   logic stage_en;

   assign stage_en = load_ev || shift_ev;
   assign stages_d = load_ev ? fifo_word.word : shift_up(stages_q, bit_in);

   // Contents left without reset on purpose
   always_ff @(posedge clk_sys) begin
      if (stage_en) begin
         stages_q <= stages_d;
      end
   end

   // ------------------------------------------------
   // Status outputs
   // ------------------------------------------------
   logic done_q;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= load_ev;
      end
   end

   assign top_stage_bit = stages_q[TOP_BIT];
   assign word_consumed = done_q;
endmodule : piso_shift_register_16

/* core/word_fifo.sv */
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : word_fifo

/* dv/pin_drv.sv */
`timescale 1ns/10ps
module pin_drv (
   input logic clk_sys,
   output logic falling_edge_clock = 1'b0
);
   task automatic pulse;
      @(posedge clk_sys) falling_edge_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      falling_edge_clock <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : pulse
endmodule : pin_drv

/* dv/piso_chk.sv */
`timescale 1ns/10ps
module piso_chk (
   input logic clk_sys,
   input logic arst_n,
   input logic falling_edge_clock,
   input logic mode_load,
   input logic chip_select_n,
   input logic top_stage_bit,
   input logic word_consumed
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_desel_hold: assert property (chip_select_n[*8]
      |-> $stable(top_stage_bit)) else $error("hold");
   a_edge_only: assert property ($changed(top_stage_bit)
      |-> $past(falling_edge_clock,6)) else $error("edge");
   a_load_pulse: assert property (word_consumed
      |=> !word_consumed) else $error("pulse");
   a_load_cause: assert property (word_consumed
      |-> $past(mode_load,5) && !$past(chip_select_n,5)) else $error("load");
   a_desel_quiet: assert property (chip_select_n[*8]
      |-> !word_consumed) else $error("desel");
   a_shift_noload: assert property (!mode_load[*8]
      |-> !word_consumed) else $error("shift");
   a_idle_quiet: assert property (!falling_edge_clock[*8]
      |-> !word_consumed) else $error("idle");
   cover property (word_consumed);
   cover property (chip_select_n[*8]);
   cover property ($changed(top_stage_bit));
endmodule : piso_chk
bind piso_shift_register_16 piso_chk u_piso_chk (.*);

/* dv/piso_shift_register_16_tb.sv */
`timescale 1ns/10ps
module piso_shift_register_16_tb;
   logic clk_sys = 0, arst_n = 0, mode_load = 0, serial_in = 0;
   logic chip_select_n = 0, parallel_word_valid = 0, falling_edge_clock;
   logic parallel_word_ready, top_stage_bit, word_consumed;
   logic [15:0] parallel_word_in = '0, e;
   int errors = 0, total_checks = 0, cyc = 0, loads = 0;
   piso_shift_register_16 u_piso_shift_register_16 (.*);
   pin_drv u_pin_drv (.*);
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc > 5000) test_done(1);
   always @(negedge clk_sys) if (word_consumed === 1'b1) loads++;
   task automatic chk(logic [15:0] s, x, string m);
      total_checks++;
      if (s !== x) $display("mismatch %s exp %h got %h", m, x, s);
      errors += int'(s !== x);
   endtask : chk
   task automatic test_done(int t);
      errors += t;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic fill_fifo;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys) parallel_word_valid <= 1;
         parallel_word_in <= {4{4'(i + 9)}};
      end
      @(posedge clk_sys) parallel_word_valid <= 0;
      @(negedge clk_sys) chk(parallel_word_ready, 16'h0000, "full");
      @(posedge clk_sys);
   endtask : fill_fifo
   task automatic run_word(int i);
      e = {4{4'(i + 9)}};
      mode_load <= 1;
      u_pin_drv.pulse();
      chk(top_stage_bit, e[15], "load");
      chk(16'(loads), 16'(i + 1), "consumed");
      {mode_load, chip_select_n} <= 2'b01;
      u_pin_drv.pulse();
      chk(top_stage_bit, e[15], "hold");
      chip_select_n <= 0;
      for (int k = 0; k < 16; k++) begin
         serial_in <= k[0];
         e = {e[14:0], k[0]};
         u_pin_drv.pulse();
         chk(top_stage_bit, e[15], "shift");
      end
   endtask : run_word
   task automatic load_empty;
      mode_load <= 1;
      u_pin_drv.pulse();
      chk(top_stage_bit, e[15], "empty");
      chk(16'(loads), 16'h0008, "refused");
      chk(parallel_word_ready, 16'h0001, "ready");
   endtask : load_empty
   initial begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1;
      fill_fifo();
      for (int i = 0; i < 8; i++) run_word(i);
      load_empty();
      test_done(0);
   end
endmodule : piso_shift_register_16_tb
